// ==== core/sfpfe_top.sv ====
// serial flash pin front end: selection, hold, lane sampling and driving
//
// What this block does
// - chip select high deselects and releases every data lane to high impedance
// - chip select low selects; instruction bytes are taken and read data returned
// - after reset nothing is accepted until chip select falls; host supplies it
// - deselection never aborts an internal cycle already running in the core
// - single mode samples instruction, address and data on lane 0 at clock rise
// - single mode shifts read data or status out on lane 1 at clock fall
// - multi-lane modes sample lanes at clock rise and drive them at clock fall
// - dual uses lanes 0 and 1; quad and quad instruction mode use lanes 0 to 3
// - quad transfers are refused unless the quad enable bit is set
// - quad enable set turns write protect into lane 2, pause into lane 3
// - write protect low blocks writes to the status registers
// - quad enable set makes the write protect function disregarded
// - pause low while selected tri-states output and ignores input and clock
// - pause released resumes the interrupted transfer from its held state
// - quad enable set disables the pause function entirely
// - hardware reset pin low returns the front end to its reset state
// - clock idling low or high at chip select edges both work
// - pause starts at its falling edge if clock low, else after next clock fall
// - pause ends at its rising edge if clock low, else after next clock fall
`timescale 1ns/1ps
module sfpfe_top (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                clk_en,
    // pins
    input  wire logic                sclk_pin,
    input  wire logic                cs_n_pin,
    input  wire logic                hw_reset_n_pin,
    input  wire logic [3:0]          io_lane_in,
    output logic      [3:0]          io_lane_out,
    output logic      [3:0]          io_lane_oe,
    // core side
    input  wire logic                quad_enable_bit,
    input  wire logic                quad_instruction_mode,
    input  wire logic                out_phase,
    input  wire sfpfe_pkg::sfpfe_width_t phase_width,
    input  wire logic [7:0]          tx_byte,
    input  wire logic                core_busy,
    output logic      [7:0]          rx_byte,
    output logic                     rx_valid,
    output logic                     rx_is_instr,
    output logic                     tx_take,
    output logic                     frame_end,
    output logic                     quad_rejected,
    output logic                     status_write_ok,
    output logic                     core_reset,
    output logic                     selected,
    output logic                     hold_active,
    output logic                     standby
);
    import sfpfe_pkg::*;

    sfpfe_pins_if pins ();

    // pin sampling into the clk domain
    sfpfe_pin_sync u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .pins_in ({io_lane_in[3], io_lane_in[2], io_lane_in[1], io_lane_in[0],
                   hw_reset_n_pin, cs_n_pin, sclk_pin}),
        .pins    (pins)
    );

    sfpfe_state_t state;
    sfpfe_state_t next_state;
    logic         first_byte;
    logic         next_first_byte;
    logic [3:0]   bit_cnt;
    logic [3:0]   next_bit_cnt;
    logic [7:0]   rx_shreg;
    logic [7:0]   next_rx_shreg;
    logic [3:0]   out_cnt;
    logic [3:0]   next_out_cnt;
    logic [7:0]   tx_shreg;
    logic [7:0]   next_tx_shreg;
    logic         driving;
    logic         next_driving;
    logic [3:0]   next_io_lane_out;
    logic [3:0]   next_io_lane_oe;
    logic [7:0]   next_rx_byte;
    logic         next_rx_valid;
    logic         next_rx_is_instr;
    logic         next_tx_take;
    logic         next_frame_end;
    logic         next_quad_rejected;
    logic         next_status_write_ok;
    logic         next_core_reset;
    logic         next_selected;
    logic         next_hold_active;
    logic         next_standby;

    // combinational helpers
    logic         sclk_low;
    logic         hold_low;
    logic         quad_instr_eff;
    logic         live;
    sfpfe_width_t width;
    logic [3:0]   step;
    logic [3:0]   oe_mask;
    logic [7:0]   in_shift;
    logic [7:0]   tx_src;
    logic [7:0]   tx_cur;
    logic [3:0]   out_bits;

    // next-state computation for the whole front end
    always_comb begin
        next_state           = state;
        next_first_byte      = first_byte;
        next_bit_cnt         = bit_cnt;
        next_rx_shreg        = rx_shreg;
        next_out_cnt         = out_cnt;
        next_tx_shreg        = tx_shreg;
        next_driving         = driving;
        next_io_lane_out     = io_lane_out;
        next_rx_byte         = rx_byte;
        next_rx_valid        = 1'b0;
        next_rx_is_instr     = rx_is_instr;
        next_tx_take         = 1'b0;
        next_frame_end       = 1'b0;
        next_quad_rejected   = quad_rejected;
        in_shift             = rx_shreg;
        tx_src               = tx_shreg;
        tx_cur               = tx_shreg;
        out_bits             = 4'h0;

        sclk_low = ~pins.level[PIN_SCLK];
        hold_low = ~quad_enable_bit & ~pins.level[PIN_LANE_3];
        quad_instr_eff = quad_instruction_mode & quad_enable_bit;

        // width of the current phase: instruction byte uses single or four lanes
        if (first_byte) begin
            width = quad_instr_eff ? W_QUAD : W_SINGLE;
        end else begin
            width = phase_width;
        end

        case (width)
            W_DUAL: begin
                step    = STEP_DUAL;
                oe_mask = OE_DUAL;
            end
            W_QUAD: begin
                step    = STEP_QUAD;
                oe_mask = OE_QUAD;
            end
            default: begin
                step    = STEP_SINGLE;
                oe_mask = OE_SINGLE;
            end
        endcase

        // edges count only while selected and not yet held
        live = ((state == ST_ACTIVE) || (state == ST_HOLD_WAIT_IN)) & ~quad_rejected;

        // quad data phase without quad enable is refused for the rest of the frame
        if (live && !first_byte && (phase_width == W_QUAD) && !quad_enable_bit) begin
            next_quad_rejected = 1'b1;
        end

        // input sampling on clock rise
        if (live && !(out_phase && !first_byte) && pins.rise[PIN_SCLK]) begin
            case (width)
                W_DUAL:  in_shift = {rx_shreg[5:0], pins.level[PIN_LANE_1], pins.level[PIN_LANE_0]};
                W_QUAD:  in_shift = {rx_shreg[3:0], pins.level[PIN_LANE_3], pins.level[PIN_LANE_2],
                                     pins.level[PIN_LANE_1], pins.level[PIN_LANE_0]};
                default: in_shift = {rx_shreg[6:0], pins.level[PIN_LANE_0]};
            endcase
            next_rx_shreg = in_shift;
            if (bit_cnt + step == BYTE_DONE) begin
                next_bit_cnt     = BIT_CNT_RST;
                next_rx_byte     = in_shift;
                next_rx_valid    = 1'b1;
                next_rx_is_instr = first_byte;
                next_first_byte  = 1'b0;
            end else begin
                next_bit_cnt = bit_cnt + step;
            end
        end

        // output shifting on clock fall
        if (live && out_phase && !first_byte && pins.fall[PIN_SCLK]) begin
            if (out_cnt == BIT_CNT_RST) begin
                tx_src       = tx_byte;
                next_tx_take = 1'b1;
            end
            tx_cur = tx_src;
            case (width)
                W_DUAL: begin
                    out_bits      = {2'b00, tx_cur[7], tx_cur[6]};
                    next_tx_shreg = {tx_cur[5:0], 2'b00};
                end
                W_QUAD: begin
                    out_bits      = tx_cur[7:4];
                    next_tx_shreg = {tx_cur[3:0], 4'h0};
                end
                default: begin
                    out_bits      = {2'b00, tx_cur[7], 1'b0};
                    next_tx_shreg = {tx_cur[6:0], 1'b0};
                end
            endcase
            next_io_lane_out = out_bits;
            next_driving     = 1'b1;
            next_out_cnt     = (out_cnt + step == BYTE_DONE) ? BIT_CNT_RST : out_cnt + step;
        end

        // selection and pause sequencing
        case (state)
            ST_DESEL: begin
                if (pins.fall[PIN_CS]) begin
                    next_state         = ST_ACTIVE;
                    next_first_byte    = 1'b1;
                    next_bit_cnt       = BIT_CNT_RST;
                    next_out_cnt       = BIT_CNT_RST;
                    next_driving       = 1'b0;
                    next_quad_rejected = 1'b0;
                end
            end
            ST_ACTIVE: begin
                if (hold_low) begin
                    next_state = sclk_low ? ST_HELD : ST_HOLD_WAIT_IN;
                end
            end
            ST_HOLD_WAIT_IN: begin
                if (pins.fall[PIN_SCLK]) begin
                    next_state = ST_HELD;
                end
            end
            ST_HELD: begin
                if (!hold_low) begin
                    next_state = sclk_low ? ST_ACTIVE : ST_HOLD_WAIT_OUT;
                end
            end
            ST_HOLD_WAIT_OUT: begin
                if (pins.fall[PIN_SCLK]) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_DESEL;
            end
        endcase

        // chip select high ends the frame and drops any partial byte
        if (state != ST_DESEL && pins.level[PIN_CS]) begin
            next_state      = ST_DESEL;
            next_frame_end  = 1'b1;
            next_bit_cnt    = BIT_CNT_RST;
            next_first_byte = 1'b1;
            next_driving    = 1'b0;
            next_rx_valid   = 1'b0;
            next_tx_take    = 1'b0;
        end

        // hardware reset pin overrides everything
        if (!pins.level[PIN_HW_RESET]) begin
            next_state         = ST_DESEL;
            next_first_byte    = 1'b1;
            next_bit_cnt       = BIT_CNT_RST;
            next_out_cnt       = BIT_CNT_RST;
            next_driving       = 1'b0;
            next_rx_valid      = 1'b0;
            next_tx_take       = 1'b0;
            next_frame_end     = 1'b0;
            next_quad_rejected = 1'b0;
        end

        // lane enables: only in an output phase that has started, never while held
        if (((next_state == ST_ACTIVE) || (next_state == ST_HOLD_WAIT_IN)) && next_driving
            && out_phase && !next_first_byte && !next_quad_rejected) begin
            next_io_lane_oe = oe_mask;
        end else begin
            next_io_lane_oe = OE_NONE;
        end

        next_status_write_ok = quad_enable_bit | pins.level[PIN_LANE_2];
        next_core_reset      = ~pins.level[PIN_HW_RESET];
        next_selected        = (next_state != ST_DESEL);
        next_hold_active     = (next_state == ST_HELD) || (next_state == ST_HOLD_WAIT_OUT);
        next_standby         = (next_state == ST_DESEL) & ~core_busy;
    end

    // state registers; core_busy is only reported, a deselect never cancels it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state           <= ST_DESEL;
            first_byte      <= 1'b1;
            bit_cnt         <= BIT_CNT_RST;
            rx_shreg        <= BYTE_RST;
            out_cnt         <= BIT_CNT_RST;
            tx_shreg        <= BYTE_RST;
            driving         <= 1'b0;
            io_lane_out     <= 4'h0;
            io_lane_oe      <= OE_NONE;
            rx_byte         <= BYTE_RST;
            rx_valid        <= 1'b0;
            rx_is_instr     <= 1'b0;
            tx_take         <= 1'b0;
            frame_end       <= 1'b0;
            quad_rejected   <= 1'b0;
            status_write_ok <= 1'b0;
            core_reset      <= 1'b0;
            selected        <= 1'b0;
            hold_active     <= 1'b0;
            standby         <= 1'b1;
        end else if (clk_en) begin
            state           <= next_state;
            first_byte      <= next_first_byte;
            bit_cnt         <= next_bit_cnt;
            rx_shreg        <= next_rx_shreg;
            out_cnt         <= next_out_cnt;
            tx_shreg        <= next_tx_shreg;
            driving         <= next_driving;
            io_lane_out     <= next_io_lane_out;
            io_lane_oe      <= next_io_lane_oe;
            rx_byte         <= next_rx_byte;
            rx_valid        <= next_rx_valid;
            rx_is_instr     <= next_rx_is_instr;
            tx_take         <= next_tx_take;
            frame_end       <= next_frame_end;
            quad_rejected   <= next_quad_rejected;
            status_write_ok <= next_status_write_ok;
            core_reset      <= next_core_reset;
            selected        <= next_selected;
            hold_active     <= next_hold_active;
            standby         <= next_standby;
        end
    end
endmodule

// ==== include/sfpfe_pkg.sv ====
// shared constants and types of the serial flash pin front end
package sfpfe_pkg;

    // pin slots in the synchronised pin vector
    localparam int unsigned NUM_PINS      = 7;
    localparam int unsigned PIN_SCLK      = 0;
    localparam int unsigned PIN_CS        = 1;
    localparam int unsigned PIN_HW_RESET  = 2;
    localparam int unsigned PIN_LANE_0    = 3;
    localparam int unsigned PIN_LANE_1    = 4;
    localparam int unsigned PIN_LANE_2    = 5;
    localparam int unsigned PIN_LANE_3    = 6;

    // synchroniser value after reset: clock low, select high, reset high, lanes 2 and 3 pulled up
    localparam logic [NUM_PINS-1:0] PIN_IDLE = 7'h66;

    // byte assembly
    localparam int unsigned  BYTE_BITS  = 8;
    localparam logic [3:0]   BIT_CNT_RST = 4'h0;
    localparam logic [3:0]   BYTE_DONE  = 4'h8;
    localparam logic [7:0]   BYTE_RST   = 8'h00;

    // lane drive masks per width
    localparam logic [3:0] OE_NONE   = 4'h0;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_DUAL   = 4'h3;
    localparam logic [3:0] OE_QUAD   = 4'hf;

    // bits moved per clock edge
    localparam logic [3:0] STEP_SINGLE = 4'h1;
    localparam logic [3:0] STEP_DUAL   = 4'h2;
    localparam logic [3:0] STEP_QUAD   = 4'h4;

    typedef enum logic [1:0] {
        W_SINGLE,
        W_DUAL,
        W_QUAD
    } sfpfe_width_t;

    typedef enum logic [2:0] {
        ST_DESEL,
        ST_ACTIVE,
        ST_HOLD_WAIT_IN,
        ST_HELD,
        ST_HOLD_WAIT_OUT
    } sfpfe_state_t;

endpackage

// ==== include/sfpfe_pins_if.sv ====
// synchronised pin levels and edges passed from the sampler to the front end
`timescale 1ns/1ps
interface sfpfe_pins_if;
    logic [sfpfe_pkg::NUM_PINS-1:0] level;
    logic [sfpfe_pkg::NUM_PINS-1:0] rise;
    logic [sfpfe_pkg::NUM_PINS-1:0] fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// ==== core/sfpfe_pin_sync.sv ====
// two-stage pin synchroniser with edge detection on the settled stage
`timescale 1ns/1ps
module sfpfe_pin_sync (
    input  wire logic                           clk,
    input  wire logic                           rstn,
    input  wire logic                           clk_en,
    input  wire logic [sfpfe_pkg::NUM_PINS-1:0] pins_in,
    sfpfe_pins_if.src                           pins
);
    import sfpfe_pkg::*;

    logic [NUM_PINS-1:0] stage1;
    logic [NUM_PINS-1:0] stage2;
    logic [NUM_PINS-1:0] stage3;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            // stage1 feeds only stage2; edges come from stage2 against stage3
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    stage1[g] <= PIN_IDLE[g];
                    stage2[g] <= PIN_IDLE[g];
                    stage3[g] <= PIN_IDLE[g];
                end else if (clk_en) begin
                    stage1[g] <= pins_in[g];
                    stage2[g] <= stage1[g];
                    stage3[g] <= stage2[g];
                end
            end
            assign pins.level[g] = stage2[g];
            assign pins.rise[g]  = stage2[g] & ~stage3[g];
            assign pins.fall[g]  = ~stage2[g] & stage3[g];
        end
    endgenerate
endmodule

// ==== tb/sfpfe_chk.sv ====
// assertions on the pins and core side of the front end
`timescale 1ns/1ps
module sfpfe_chk (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    cs_n_pin,
    input  wire logic                    hw_reset_n_pin,
    input  wire logic [3:0]              io_lane_in,
    input  wire logic [3:0]              io_lane_oe,
    input  wire logic                    quad_enable_bit,
    input  wire sfpfe_pkg::sfpfe_width_t phase_width,
    input  wire logic                    core_busy,
    input  wire logic                    tx_take,
    input  wire logic                    frame_end,
    input  wire logic                    core_reset,
    input  wire logic                    selected,
    input  wire logic                    hold_active,
    input  wire logic                    standby,
    input  wire logic                    status_write_ok
);
    import sfpfe_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // select pin edges seen from each side of selection
    sequence cs_rise_sel;
        selected && $rose(cs_n_pin);
    endsequence
    sequence cs_fall_idle;
        !selected && hw_reset_n_pin && $fell(cs_n_pin);
    endsequence
    sequence quad_on_held;
        quad_enable_bit [*2];
    endsequence
    AST_DESEL_HIZ: assert property (!selected |-> io_lane_oe == OE_NONE) else $error("lanes driven idle");
    AST_SELECT: assert property (cs_fall_idle |-> ##[1:6] selected) else $error("no selection");
    AST_FRAME_END: assert property (cs_rise_sel |-> ##[1:6] frame_end) else $error("no frame end");
    AST_CORE_RST: assert property ($fell(hw_reset_n_pin) |-> ##[2:4] core_reset) else $error("no reset");
    AST_RST_DESEL: assert property (core_reset |=> !selected) else $error("selected in reset");
    AST_HOLD_HIZ: assert property (hold_active |-> io_lane_oe == OE_NONE) else $error("driven in hold");
    AST_QUAD_NOPAUSE: assert property (quad_on_held |-> !hold_active) else $error("hold with quad on");
    AST_QUAD_WP: assert property (quad_on_held |-> status_write_ok) else $error("protect with quad on");
    AST_WP_BLOCK: assert property ((!io_lane_in[2] && !quad_enable_bit) [*5] |-> !status_write_ok)
        else $error("status write not blocked");
    AST_BUSY: assert property (core_busy [*2] |-> !standby) else $error("standby while busy");
    AST_TX_WIDTH: assert property (tx_take |-> io_lane_oe == (phase_width == W_SINGLE ? OE_SINGLE :
        phase_width == W_DUAL ? OE_DUAL : OE_QUAD)) else $error("wrong lanes driven");
endmodule

// ==== tb/sfpfe_host.sv ====
// host controller model: link clock, select, reset and lane levels
`timescale 1ns/1ps
module sfpfe_host (
    input  wire logic       clk,
    input  wire logic [3:0] io_lane_out,
    input  wire logic [3:0] io_lane_oe,
    output logic            sclk_pin,
    output logic            cs_n_pin,
    output logic            hw_reset_n_pin,
    output logic [3:0]      io_lane_in
);
    logic [3:0] drv  = 4'hc;
    logic [3:0] val  = 4'hf;
    logic       tog  = 1'b0;
    logic       cpol = 1'b0;
    initial begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
        hw_reset_n_pin = 1'b1;
    end
    // released lanes 0 and 1 keep changing, lanes 2 and 3 pulled up
    always @(negedge clk) tog <= ~tog;
    assign io_lane_in = (io_lane_oe & io_lane_out) | (~io_lane_oe & drv & val)
        | (~io_lane_oe & ~drv & {2'b11, tog, ~tog});
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // select with the clock idle, then take it low
    task automatic begin_frame();
        tick(1);
        cs_n_pin = 1'b0;
        tick(5);
        sclk_pin = 1'b0;
    endtask
    // clock back to idle, then deselect; select stays low until here
    task automatic end_frame();
        tick(5);
        sclk_pin = cpol;
        tick(5);
        cs_n_pin = 1'b1;
        drv = 4'hc;
        val[3:2] = 2'b11;
    endtask
    // n clock periods of s lanes, msb first: set while low, taken at rise
    task automatic xfer(input logic [7:0] b, input int s, input int n, input bit rd, output logic [7:0] got);
        logic [3:0] m;
        m = 4'((1 << s) - 1);
        got = 8'h00;
        drv = rd ? (drv & ~m) : (drv | m);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < s; k++) if (!rd) val[s-1-k] = b[7-k];
            b = b << s;
            tick(5);
            for (int k = 0; k < s; k++) if (rd) got = {got[6:0], io_lane_in[s == 1 ? 1 : s-1-k]};
            sclk_pin = 1'b1;
            tick(5);
            sclk_pin = 1'b0;
        end
    endtask
endmodule

// ==== tb/sfpfe_top_bench.sv ====
// self-checking bench of the serial flash pin front end
`timescale 1ns/1ps
module sfpfe_top_bench;
    import sfpfe_pkg::*;
    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         clk_en = 1'b1;
    logic         sclk_pin, cs_n_pin, hw_reset_n_pin;
    logic [3:0]   io_lane_in, io_lane_out, io_lane_oe;
    logic         quad_enable_bit = 1'b0;
    logic         quad_instruction_mode = 1'b0;
    logic         out_phase = 1'b0;
    sfpfe_width_t phase_width = W_SINGLE;
    logic [7:0]   tx_byte = 8'h00;
    logic         core_busy = 1'b0;
    logic [7:0]   rx_byte, ins, dat, got;
    logic         rx_valid, rx_is_instr, tx_take, frame_end, quad_rejected;
    logic         status_write_ok, core_reset, selected, hold_active, standby;
    logic [8:0]   exp_q[$];
    logic [8:0]   e;
    logic [31:0]  seed = 32'h3787;
    int           bad_count = 0;
    int           n_tests = 0;

    always #4 clk = ~clk;
    sfpfe_top uut (.*);
    sfpfe_host host (.*);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd(output logic [7:0] v);
        seed = lfsr(seed);
        v = seed[7:0];
    endtask
    task automatic chk(input logic [8:0] g, input logic [8:0] x);
        n_tests++;
        if (g !== x) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // bounded wait for the selection state
    task automatic wait_sel(input logic v);
        int i;
        for (i = 0; i < 40 && selected !== v; i++) @(negedge clk);
        if (i == 40) begin
            bad_count++;
            $display("BAD t=%0t selected=%h exp=%h", $time, selected, v);
            test_done();
        end
    endtask
    // instruction then one data byte: nd 1 = data, 2 = refused quad data
    task automatic frame(input int w, input bit rd, input int nd);
        rnd(ins);
        rnd(dat);
        phase_width = sfpfe_width_t'(w);
        out_phase = rd;
        tx_byte = dat;
        host.begin_frame();
        wait_sel(1'b1);
        exp_q.push_back({1'b1, ins});
        if (quad_instruction_mode && quad_enable_bit) host.xfer(ins, 4, 2, 1'b0, got);
        else host.xfer(ins, 1, 8, 1'b0, got);
        if (nd == 2) begin
            host.xfer(8'hff, 4, 2, 1'b0, got);
            chk(9'(quad_rejected), 9'h001);
        end else if (rd) begin
            host.xfer(8'h00, 1 << w, 8 >> w, 1'b1, got);
            chk({1'b0, got}, {1'b0, dat});
        end else begin
            exp_q.push_back({1'b0, dat});
            host.xfer(dat, 1 << w, 8 >> w, 1'b0, got);
        end
        host.end_frame();
        wait_sel(1'b0);
    endtask

    // each received byte against the oldest note
    always @(negedge clk) begin
        if (rx_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : ~{rx_is_instr, rx_byte};
            chk({rx_is_instr, rx_byte}, e);
        end
    end

    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk({7'h00, standby, io_lane_oe != 4'h0}, 9'h002);
        // every lane width, written and read
        for (int w = 0; w < 3; w++) begin
            quad_enable_bit = (w == 2);
            frame(w, 1'b0, 1);
            frame(w, 1'b1, 1);
        end
        quad_instruction_mode = 1'b1;
        frame(2, 1'b0, 1);
        quad_instruction_mode = 1'b0;
        quad_enable_bit = 1'b0;
        frame(2, 1'b0, 2);
        // clock idling high at the select edges
        host.cpol = 1'b1;
        host.sclk_pin = 1'b1;
        frame(0, 1'b0, 1);
        host.cpol = 1'b0;
        host.sclk_pin = 1'b0;
        // partial instruction then deselect: no byte expected
        host.begin_frame();
        wait_sel(1'b1);
        host.xfer(8'h5a, 1, 5, 1'b0, got);
        host.end_frame();
        wait_sel(1'b0);
        // pause in mid instruction with clock low, garbage edges while held
        rnd(ins);
        host.begin_frame();
        wait_sel(1'b1);
        exp_q.push_back({1'b1, ins});
        host.xfer(ins, 1, 4, 1'b0, got);
        host.val[3] = 1'b0;
        repeat (6) @(negedge clk);
        chk(9'(hold_active), 9'h001);
        host.xfer(8'h00, 1, 3, 1'b0, got);
        host.val[3] = 1'b1;
        repeat (6) @(negedge clk);
        chk(9'(hold_active), 9'h000);
        host.xfer({ins[3:0], 4'h0}, 1, 4, 1'b0, got);
        host.end_frame();
        wait_sel(1'b0);
        // pause pin ignored with quad enabled
        quad_enable_bit = 1'b1;
        host.begin_frame();
        wait_sel(1'b1);
        host.val[3] = 1'b0;
        repeat (6) @(negedge clk);
        chk(9'(hold_active), 9'h000);
        host.end_frame();
        wait_sel(1'b0);
        // write protect against quad enable
        for (int i = 0; i < 4; i++) begin
            quad_enable_bit = i[1];
            host.val[2] = i[0];
            repeat (8) @(negedge clk);
            chk(9'(status_write_ok), 9'(i[1] | i[0]));
        end
        host.val[2] = 1'b1;
        quad_enable_bit = 1'b0;
        core_busy = 1'b1;
        repeat (3) @(negedge clk);
        chk(9'(standby), 9'h000);
        // clock enable low freezes standby although the core went idle
        clk_en = 1'b0;
        core_busy = 1'b0;
        repeat (3) @(negedge clk);
        chk(9'(standby), 9'h000);
        clk_en = 1'b1;
        repeat (3) @(negedge clk);
        chk(9'(standby), 9'h001);
        // hardware reset in mid frame
        host.begin_frame();
        wait_sel(1'b1);
        host.hw_reset_n_pin = 1'b0;
        repeat (6) @(negedge clk);
        chk({7'h00, core_reset, selected}, 9'h002);
        host.hw_reset_n_pin = 1'b1;
        host.end_frame();
        wait_sel(1'b0);
        repeat (10) @(negedge clk);
        chk(9'(exp_q.size()), 9'h000);
        test_done();
    end
endmodule

bind sfpfe_top sfpfe_chk u_chk (.*);
